// ==== csr_div_decode.sv ====
// ratio field decode into division factor
`timescale 1ns/1ps
`include "csr_regs.svh"
module csr_div_decode (
    // ratio field
    input  wire logic [2:0] ratio,
    // decoded
    output logic      [2:0] factor,
    output logic            legal
);
    always_comb begin
        factor = 3'h4;
        legal  = 1'b1;
        case (ratio)
            csr_pkg::CSR_DIV2: factor = 3'h2;
            csr_pkg::CSR_DIV3: factor = 3'h3;
            csr_pkg::CSR_DIV4: factor = 3'h4;
            csr_pkg::CSR_DIV5: factor = 3'h5;
            csr_pkg::CSR_DIV6: factor = 3'h6;
            default: begin
                // unlisted codes fall back to four, never below two
                factor = 3'h4;
                legal  = 1'b0;
            end
        endcase
    end
endmodule

// ==== csr_host_model.sv ====
// host software model driving the register port of the routing block
`timescale 1ns/1ps
`include "csr_regs.svh"
module csr_host_model (
    // clock
    input  wire logic                   clk,
    // register port
    output logic      [`CSR_ADDR_W-1:0] addr,
    output logic      [7:0]             wdata,
    output logic                        wr,
    output logic                        rd,
    input  wire logic [7:0]             rdata
);
    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    initial begin
        addr  = 10'h000;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    task automatic write_reg(input logic [`CSR_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // data stand only in the cycle after the read strobe
    task automatic read_reg(input logic [`CSR_ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    // ----------------------------------------
    // software sequences
    // ----------------------------------------
    task automatic update();
        write_reg(`CSR_OFF_UPDATE, `CSR_UPDATE_CMD);
    endtask

    // bypass only for an external source kept below the channel limit
    task automatic set_route(input logic src, input logic byp);
        write_reg(`CSR_OFF_ROUTE, {6'h00, src, byp & ~src});
    endtask

    // other loop fields left at zero: simplest legal setup
    task automatic set_loop(input logic on, input logic neg);
        write_reg(`CSR_OFF_LOOP, {neg, 5'h00, 1'b0, ~on});
    endtask

    // calibration bit cleared and applied first, then set and applied, so done is left and a new run starts
    task automatic cal_restart();
        write_reg(`CSR_OFF_CAL, 8'h00);
        update();
        write_reg(`CSR_OFF_CAL, 8'h01);
        update();
    endtask
endmodule

// ==== csr_pkg.sv ====
// types for clock source routing control
package csr_pkg;
    typedef enum logic [1:0] {
        CSR_CAL_IDLE  = 2'b00,
        CSR_CAL_RUN   = 2'b01,
        CSR_CAL_DONE  = 2'b10
    } csr_cal_state_t;

    typedef enum logic [2:0] {
        CSR_DIV2 = 3'b000,
        CSR_DIV3 = 3'b001,
        CSR_DIV4 = 3'b010,
        CSR_DIV5 = 3'b011,
        CSR_DIV6 = 3'b100
    } csr_div_t;
endpackage

// ==== csr_regs.svh ====
// register offsets, field positions, reset values and timing for clock source routing
`ifndef CSR_REGS_SVH
`define CSR_REGS_SVH

`define CSR_ADDR_W          10
`define CSR_OFF_LOOP        10'h010
`define CSR_OFF_CAL         10'h018
`define CSR_OFF_PREDIV      10'h1e0
`define CSR_OFF_ROUTE       10'h1e1
`define CSR_OFF_UPDATE      10'h232
`define CSR_OFF_STATUS      10'h233

`define CSR_LOOP_PWR_LSB    0
`define CSR_LOOP_POL_BIT    7
`define CSR_CAL_BIT         0
`define CSR_ROUTE_BYP_BIT   0
`define CSR_ROUTE_SRC_BIT   1
`define CSR_UPDATE_BIT      0

`define CSR_LOOP_RST        8'h01
`define CSR_CAL_RST         8'h00
`define CSR_PREDIV_RST      8'h02
`define CSR_ROUTE_RST       8'h00
`define CSR_UPDATE_CMD      8'h01

`define CSR_PWR_NORMAL      2'h0
`define CSR_PWR_DOWN        2'h1

`define CSR_CLK_MHZ         25
`define CSR_CAL_TIME_NS     400
`define CSR_CAL_CYCLES      ((`CSR_CAL_TIME_NS * `CSR_CLK_MHZ + 999) / 1000)

`endif

// ==== csr_route_ctrl.sv ====
// clock source routing, pre-divider and loop control registers
`timescale 1ns/1ps
`include "csr_regs.svh"
module csr_route_ctrl #(
    parameter int CAL_CYCLES = `CSR_CAL_CYCLES
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset,
    // register port
    input  wire logic [`CSR_ADDR_W-1:0]  addr,
    input  wire logic [7:0]              wdata,
    input  wire logic                    wr,
    input  wire logic                    rd,
    output logic      [7:0]              rdata,
    // routing controls
    output logic                         src_osc,
    output logic                         prediv_bypass,
    output logic      [2:0]              prediv_factor,
    output logic                         loop_pwr_down,
    output logic                         pol_negative,
    output logic                         osc_enable,
    output logic                         cal_busy
);
    // ------------------------------------------------------------
    // staging registers
    // ------------------------------------------------------------
    logic [7:0] loop_stg_q;
    logic [7:0] cal_stg_q;
    logic [7:0] prediv_stg_q;
    logic [7:0] route_stg_q;
    logic [7:0] loop_act_q;
    logic [7:0] cal_act_q;
    logic [7:0] prediv_act_q;
    logic [7:0] route_act_q;
    logic       update_q;
    logic       do_update;
    logic [2:0] factor_d;
    logic       ratio_legal;
    logic [15:0] cal_cnt_q;
    csr_pkg::csr_cal_state_t cal_st_q;

    assign do_update = wr && (addr == `CSR_OFF_UPDATE) && (wdata == `CSR_UPDATE_CMD);

    always_ff @(posedge clk) begin
        if (reset) begin
            loop_stg_q   <= `CSR_LOOP_RST;
            cal_stg_q    <= `CSR_CAL_RST;
            prediv_stg_q <= `CSR_PREDIV_RST;
            route_stg_q  <= `CSR_ROUTE_RST;
        end else if (wr) begin
            case (addr)
                `CSR_OFF_LOOP:   loop_stg_q   <= wdata;
                `CSR_OFF_CAL:    cal_stg_q    <= wdata;
                `CSR_OFF_PREDIV: prediv_stg_q <= wdata;
                `CSR_OFF_ROUTE:  route_stg_q  <= wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // active registers, loaded together on update
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            loop_act_q   <= `CSR_LOOP_RST;
            cal_act_q    <= `CSR_CAL_RST;
            prediv_act_q <= `CSR_PREDIV_RST;
            route_act_q  <= `CSR_ROUTE_RST;
        end else if (do_update) begin
            // the update write itself cannot stage, so prior writes are taken
            loop_act_q   <= loop_stg_q;
            cal_act_q    <= cal_stg_q;
            prediv_act_q <= prediv_stg_q;
            route_act_q  <= route_stg_q;
        end
    end

    // update bit reads one for one cycle, then self-clears
    always_ff @(posedge clk) begin
        if (reset) begin
            update_q <= 1'b0;
        end else begin
            update_q <= do_update;
        end
    end

    // ------------------------------------------------------------
    // pre-divider decode
    // ------------------------------------------------------------
    csr_div_decode u_dec (
        .ratio  (prediv_act_q[2:0]),
        .factor (factor_d),
        .legal  (ratio_legal)
    );

    // ------------------------------------------------------------
    // calibration sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            cal_st_q  <= csr_pkg::CSR_CAL_IDLE;
            cal_cnt_q <= 16'h0000;
        end else begin
            case (cal_st_q)
                csr_pkg::CSR_CAL_IDLE: begin
                    if (do_update && cal_stg_q[`CSR_CAL_BIT]) begin
                        cal_st_q  <= csr_pkg::CSR_CAL_RUN;
                        cal_cnt_q <= 16'(CAL_CYCLES - 1);
                    end
                end
                csr_pkg::CSR_CAL_RUN: begin
                    if (do_update && !cal_stg_q[`CSR_CAL_BIT]) begin
                        cal_st_q <= csr_pkg::CSR_CAL_IDLE;
                    end else if (cal_cnt_q == 16'h0000) begin
                        cal_st_q <= csr_pkg::CSR_CAL_DONE;
                    end else begin
                        cal_cnt_q <= cal_cnt_q - 16'h0001;
                    end
                end
                csr_pkg::CSR_CAL_DONE: begin
                    // a new start needs a clear-and-update first
                    if (do_update && !cal_stg_q[`CSR_CAL_BIT]) begin
                        cal_st_q <= csr_pkg::CSR_CAL_IDLE;
                    end
                end
                default: cal_st_q <= csr_pkg::CSR_CAL_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // routing outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            src_osc       <= 1'b0;
            prediv_bypass <= 1'b0;
            osc_enable    <= 1'b0;
        end else begin
            src_osc       <= route_act_q[`CSR_ROUTE_SRC_BIT];
            prediv_bypass <= route_act_q[`CSR_ROUTE_BYP_BIT];
            // oscillator powered only while it is the source
            osc_enable    <= route_act_q[`CSR_ROUTE_SRC_BIT];
        end
    end

    // ------------------------------------------------------------
    // pre-divider factor
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            prediv_factor <= 3'h4;
        end else begin
            prediv_factor <= factor_d;
        end
    end

    // ------------------------------------------------------------
    // loop power and polarity
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            loop_pwr_down <= 1'b1;
            pol_negative  <= 1'b0;
        end else begin
            // only 00b runs the loop; other codes treated as power-down
            loop_pwr_down <= loop_act_q[1:0] != `CSR_PWR_NORMAL;
            pol_negative  <= loop_act_q[`CSR_LOOP_POL_BIT];
        end
    end

    // ------------------------------------------------------------
    // calibration busy flag
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            cal_busy <= 1'b0;
        end else begin
            cal_busy <= cal_st_q == csr_pkg::CSR_CAL_RUN;
        end
    end

    // ------------------------------------------------------------
    // read port: staged values, status shows active state
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                `CSR_OFF_LOOP:   rdata <= loop_stg_q;
                `CSR_OFF_CAL:    rdata <= cal_stg_q;
                `CSR_OFF_PREDIV: rdata <= prediv_stg_q;
                `CSR_OFF_ROUTE:  rdata <= route_stg_q;
                `CSR_OFF_UPDATE: rdata <= {7'h00, update_q};
                `CSR_OFF_STATUS: rdata <= {2'h0, ratio_legal, cal_st_q,
                                           ~loop_pwr_down, src_osc, prediv_bypass};
                default:         rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // outputs lag the active registers by one edge
    reset_default_a: assert property (
        @(posedge clk) reset
        |=> loop_pwr_down && !src_osc && !prediv_bypass && prediv_factor == 3'h4)
        else $error("reset defaults wrong");
    min_divide_a: assert property (
        @(posedge clk) disable iff (reset)
        prediv_factor >= 3'h2 && prediv_factor <= 3'h6)
        else $error("pre-divider outside two to six");
    no_early_apply_a: assert property (
        @(posedge clk) disable iff (reset)
        !do_update |=> $stable(route_act_q) && $stable(loop_act_q))
        else $error("setting applied without update");
    update_apply_a: assert property (
        @(posedge clk) disable iff (reset)
        do_update |=> route_act_q == $past(route_stg_q) && prediv_act_q == $past(prediv_stg_q))
        else $error("staged settings not applied");
    src_route_a: assert property (
        @(posedge clk) disable iff (reset)
        do_update ##1 !do_update |=> src_osc == route_act_q[`CSR_ROUTE_SRC_BIT])
        else $error("source select not routed");
    bypass_route_a: assert property (
        @(posedge clk) disable iff (reset)
        1'b1 |=> prediv_bypass == $past(route_act_q[`CSR_ROUTE_BYP_BIT]))
        else $error("bypass not routed");
    loop_power_a: assert property (
        @(posedge clk) disable iff (reset)
        1'b1 |=> loop_pwr_down == ($past(loop_act_q[1:0]) != 2'h0))
        else $error("loop power wrong");
    loop_polarity_a: assert property (
        @(posedge clk) disable iff (reset)
        1'b1 |=> pol_negative == $past(loop_act_q[7]))
        else $error("polarity wrong");
    osc_off_a: assert property (
        @(posedge clk) disable iff (reset)
        !src_osc |-> !osc_enable)
        else $error("oscillator on with external source");
    cal_start_a: assert property (
        @(posedge clk) disable iff (reset)
        cal_st_q == csr_pkg::CSR_CAL_IDLE && do_update && cal_stg_q[0] |=> ##1 cal_busy)
        else $error("calibration did not start");
    defaults_kept_a: assert property (
        @(posedge clk) reset
        |=> loop_stg_q == 8'h01 && prediv_stg_q == 8'h02 && route_stg_q == 8'h00)
        else $error("defaults not restored");
    ratio_map_a: assert property (
        @(posedge clk) disable iff (reset)
        prediv_act_q[2:0] == 3'b010 |=> prediv_factor == 3'h4)
        else $error("ratio code wrong");
    route_stage_a: assert property (
        @(posedge clk) disable iff (reset)
        wr && addr == `CSR_OFF_ROUTE |=> route_stg_q == $past(wdata))
        else $error("route write not staged");
    ratio_stage_a: assert property (
        @(posedge clk) disable iff (reset)
        wr && addr == `CSR_OFF_PREDIV |=> prediv_stg_q == $past(wdata))
        else $error("ratio write not staged");
    bad_update_a: assert property (
        @(posedge clk) disable iff (reset)
        wr && addr == `CSR_OFF_UPDATE && wdata != `CSR_UPDATE_CMD
        |=> $stable(prediv_act_q) && $stable(cal_act_q))
        else $error("wrong update code applied settings");
    loop_apply_a: assert property (
        @(posedge clk) disable iff (reset)
        do_update |=> loop_act_q == $past(loop_stg_q) && cal_act_q == $past(cal_stg_q))
        else $error("loop or calibration settings not applied");
    update_clear_a: assert property (
        @(posedge clk) disable iff (reset)
        do_update ##1 !do_update |=> !update_q)
        else $error("update bit did not clear");
    update_read_a: assert property (
        @(posedge clk) disable iff (reset)
        rd && addr == `CSR_OFF_UPDATE |=> rdata == {7'h00, $past(update_q)})
        else $error("update bit read wrong");
    stage_read_a: assert property (
        @(posedge clk) disable iff (reset)
        rd && addr == `CSR_OFF_ROUTE |=> rdata == $past(route_stg_q))
        else $error("staged route read wrong");
    cal_finish_a: assert property (
        @(posedge clk) disable iff (reset)
        cal_st_q == csr_pkg::CSR_CAL_RUN && cal_cnt_q == 16'h0000 && !do_update
        |=> cal_st_q == csr_pkg::CSR_CAL_DONE)
        else $error("calibration did not finish");
    cal_clear_a: assert property (
        @(posedge clk) disable iff (reset)
        do_update && !cal_stg_q[`CSR_CAL_BIT] |=> cal_st_q == csr_pkg::CSR_CAL_IDLE)
        else $error("calibration not reset");
    cal_hold_a: assert property (
        @(posedge clk) disable iff (reset)
        cal_st_q == csr_pkg::CSR_CAL_DONE && !do_update
        |=> cal_st_q == csr_pkg::CSR_CAL_DONE)
        else $error("calibration left done without update");
    busy_track_a: assert property (
        @(posedge clk) disable iff (reset)
        1'b1 |=> cal_busy == ($past(cal_st_q) == csr_pkg::CSR_CAL_RUN))
        else $error("calibration busy wrong");
    osc_follow_a: assert property (
        @(posedge clk) disable iff (reset)
        1'b1 |=> osc_enable == $past(route_act_q[`CSR_ROUTE_SRC_BIT]))
        else $error("oscillator enable wrong");
    legal_fallback_a: assert property (
        @(posedge clk) disable iff (reset)
        !ratio_legal |=> prediv_factor == 3'h4)
        else $error("unlisted ratio code not four");
    reset_active_a: assert property (
        @(posedge clk) reset
        |=> loop_act_q == `CSR_LOOP_RST && prediv_act_q == `CSR_PREDIV_RST
            && route_act_q == `CSR_ROUTE_RST)
        else $error("active defaults not restored");

    // ------------------------------------------------------------
    // coverage
    // ------------------------------------------------------------
    // covers show a scenario was reached, not that it was right
    update_cov_c: cover property (@(posedge clk) disable iff (reset) do_update);
    osc_cov_c: cover property (@(posedge clk) disable iff (reset) src_osc && !loop_pwr_down);
    bypass_cov_c: cover property (@(posedge clk) disable iff (reset) prediv_bypass);
    cal_cov_c: cover property (@(posedge clk) disable iff (reset)
        cal_st_q == csr_pkg::CSR_CAL_DONE);
    restart_cov_c: cover property (@(posedge clk) disable iff (reset)
        do_update && !cal_stg_q[`CSR_CAL_BIT] && cal_st_q == csr_pkg::CSR_CAL_DONE);
endmodule

// ==== csr_route_ctrl_bench.sv ====
// self-checking bench for clock source routing control
`timescale 1ns/1ps
`include "csr_regs.svh"
module csr_route_ctrl_bench;
    localparam int CAL_N = 6;
    logic                   clk = 1'b0;
    logic                   reset = 1'b1;
    logic [`CSR_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
    logic                   wr;
    logic                   rd;
    logic [7:0]             rdata;
    logic                   src_osc, prediv_bypass, loop_pwr_down;
    logic                   pol_negative, osc_enable, cal_busy;
    logic [2:0]             prediv_factor;
    logic [8:0]             outs;
    logic [7:0]             rv;
    logic [2:0]             ef;
    int                     fail_count = 0;
    int                     num_checks = 0;
    int                     n;

    always #20 clk = ~clk;
    assign outs = {src_osc, prediv_bypass, prediv_factor, loop_pwr_down,
                   pol_negative, osc_enable, cal_busy};

    csr_host_model u_csr_host_model (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
                                     .rd(rd), .rdata(rdata));
    csr_route_ctrl #(.CAL_CYCLES(CAL_N)) u_csr_route_ctrl (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .src_osc(src_osc), .prediv_bypass(prediv_bypass),
        .prediv_factor(prediv_factor), .loop_pwr_down(loop_pwr_down),
        .pol_negative(pol_negative), .osc_enable(osc_enable), .cal_busy(cal_busy));

    // ----------------------------------------
    // checking
    // ----------------------------------------
    function automatic logic [8:0] exp_o(input logic s, input logic b, input logic [2:0] f,
                                         input logic dn, input logic ng, input logic by);
        return {s, b, f, dn, ng, s, by};
    endfunction

    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_out(input logic [8:0] e);
        num_checks++;
        if (outs !== e) begin
            fail_count++;
            $display("Error outputs expected %h seen %h", e, outs);
        end
    endtask

    task automatic rd_chk(input logic [`CSR_ADDR_W-1:0] a, input logic [7:0] e);
        u_csr_host_model.read_reg(a, rv);
        chk_reg("read data", e, rv);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk_out(exp_o(1'b0, 1'b0, 3'h4, 1'b1, 1'b0, 1'b0));
        rd_chk(`CSR_OFF_LOOP, 8'h01);
        rd_chk(`CSR_OFF_CAL, 8'h00);
        rd_chk(`CSR_OFF_PREDIV, 8'h02);
        rd_chk(`CSR_OFF_ROUTE, 8'h00);
        rd_chk(10'h100, 8'h00);
        $display("test defaults done");

        u_csr_host_model.set_route(1'b0, 1'b1);
        #1;
        chk_out(exp_o(1'b0, 1'b0, 3'h4, 1'b1, 1'b0, 1'b0));
        u_csr_host_model.write_reg(`CSR_OFF_UPDATE, 8'h02);
        settle();
        chk_out(exp_o(1'b0, 1'b0, 3'h4, 1'b1, 1'b0, 1'b0));
        u_csr_host_model.update();
        settle();
        chk_out(exp_o(1'b0, 1'b1, 3'h4, 1'b1, 1'b0, 1'b0));
        rd_chk(`CSR_OFF_ROUTE, 8'h01);
        rd_chk(`CSR_OFF_UPDATE, 8'h00);
        $display("test staging done");

        u_csr_host_model.set_route(1'b1, 1'b0);
        // codes 5..7 first, ending on code 4 so later steps see six
        for (int i = 5; i < 13; i++) begin
            u_csr_host_model.write_reg(`CSR_OFF_PREDIV, 8'(i % 8));
            u_csr_host_model.update();
            settle();
            ef = (i % 8 < 5) ? 3'(i % 8 + 2) : 3'h4;
            chk_out(exp_o(1'b1, 1'b0, ef, 1'b1, 1'b0, 1'b0));
        end
        $display("test ratio done");

        u_csr_host_model.set_route(1'b0, 1'b0);
        u_csr_host_model.set_loop(1'b1, 1'b1);
        u_csr_host_model.update();
        settle();
        chk_out(exp_o(1'b0, 1'b0, 3'h6, 1'b0, 1'b1, 1'b0));
        rd_chk(`CSR_OFF_STATUS, 8'h24);
        u_csr_host_model.set_loop(1'b0, 1'b0);
        u_csr_host_model.update();
        settle();
        chk_out(exp_o(1'b0, 1'b0, 3'h6, 1'b1, 1'b0, 1'b0));
        $display("test loop done");

        u_csr_host_model.set_route(1'b1, 1'b0);
        u_csr_host_model.write_reg(`CSR_OFF_CAL, 8'h01);
        u_csr_host_model.update();
        settle();
        chk_out(exp_o(1'b1, 1'b0, 3'h6, 1'b1, 1'b0, 1'b1));
        n = 0;
        while (cal_busy !== 1'b0 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 40) begin
            fail_count++;
            $display("Error cal_busy expected 0 seen %b", cal_busy);
            tally_and_finish();
        end
        chk_reg("cal length", 8'(CAL_N - 2), 8'(n));
        u_csr_host_model.update();
        settle();
        chk_out(exp_o(1'b1, 1'b0, 3'h6, 1'b1, 1'b0, 1'b0));
        u_csr_host_model.cal_restart();
        settle();
        chk_out(exp_o(1'b1, 1'b0, 3'h6, 1'b1, 1'b0, 1'b1));
        $display("test calibration done");

        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk_out(exp_o(1'b0, 1'b0, 3'h4, 1'b1, 1'b0, 1'b0));
        rd_chk(`CSR_OFF_PREDIV, 8'h02);
        rd_chk(`CSR_OFF_ROUTE, 8'h00);
        $display("test reset done");
        tally_and_finish();
    end
endmodule
